// File: src/ext_interrupt_sense_and_vector_map.v
// Top of the external interrupt sense logic and interrupt vector map.
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "irq_map_regs.vh"
module ext_interrupt_sense_and_vector_map #(
  parameter ADDR_W = 4,
  parameter GRP_A_PINS = 6,
  parameter GRP_B_PINS = 4,
  parameter GRP_C_PINS = 6,
  parameter [GRP_A_PINS-1:0] GRP_A_INV_MASK = 6'h38,
  parameter [GRP_C_PINS-1:0] GRP_C_INV_MASK = 6'h38
) (
  // Clock, reset and clock enable.
  input wire clk,
  input wire srst,
  input wire clk_en,

  // Register port.
  input wire [ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,

  // CPU software priority bits.
  input wire cpu_priority_high_bit,
  input wire cpu_priority_low_bit,

  // External port interrupt pins.
  input wire [GRP_A_PINS-1:0] ext_line_group_a,
  input wire [GRP_B_PINS-1:0] ext_line_group_b,
  input wire [GRP_C_PINS-1:0] ext_line_group_c,

  // Port configuration: pin used as interrupt input, pin driven to ground.
  input wire [GRP_A_PINS-1:0] group_a_irq_en,
  input wire [GRP_B_PINS-1:0] group_b_irq_en,
  input wire [GRP_C_PINS-1:0] group_c_irq_en,
  input wire [GRP_A_PINS-1:0] group_a_drive_low,
  input wire [GRP_B_PINS-1:0] group_b_drive_low,
  input wire [GRP_C_PINS-1:0] group_c_drive_low,

  // Peripheral interrupt sources.
  input wire motor_emergency_stop,
  input wire clock_timebase_unit_irq,
  input wire safe_oscillator_switch_irq,
  input wire motor_controller_u_irq,
  input wire motor_controller_loop_irq,
  input wire motor_controller_sample_irq,
  input wire motor_controller_r_irq,
  input wire motor_controller_z_irq,
  input wire motor_controller_c_irq,
  input wire motor_controller_d_irq,
  input wire spi_irq,
  input wire timer_a_irq,
  input wire timer_b_irq,
  input wire async_serial_irq,
  input wire aux_voltage_detector_irq,
  input wire adc_eoc_irq,
  input wire auto_reload_pwm_timer_irq,

  // Low-power state.
  input wire halt_mode,
  input wire active_halt_mode,

  // Service entry from the interrupt sequencer.
  input wire irq_ack,
  input wire [3:0] irq_ack_vector,

  // Request to the interrupt sequencer.
  output reg irq_valid_q,
  output reg [3:0] irq_vector_q,
  output reg [15:0] irq_vector_addr_q,
  output reg halt_wake_q,
  output reg [2:0] ext_request_q,

  // Sensitivity control contents.
  output reg [7:0] sens_ctrl_q
);

  // ==========================================================================
  // Register decode
  // ==========================================================================

  // Offset 0 holds the sensitivity control. Offset 1 reads the group masks, the
  // refused-write flag and the pending edges; offset 2 reads the vector that the
  // encoder selects now. Other offsets read as zero and ignore writes.

  wire sel_ctrl = (reg_addr == `SENS_CTRL_OFS);

  // Only software level 3 may change the control; a write at any other level
  // is dropped and remembered in a flag that software can read back.
  wire level3 = ({cpu_priority_high_bit, cpu_priority_low_bit} == `PRIO_LEVEL3);

  wire ctrl_wr = reg_wr & sel_ctrl;
  wire ctrl_accept = ctrl_wr & level3;

  // Rewriting the current value leaves the pending edges alone.
  wire cfg_change = ctrl_accept & (reg_wdata != sens_ctrl_q);

  // Set by a refused write and cleared by the next accepted one.
  reg write_refused_q;
  reg write_refused_d;
  reg [7:0] sens_ctrl_d;

  always @* begin
    sens_ctrl_d = sens_ctrl_q;
    write_refused_d = write_refused_q;
    if (ctrl_accept) begin
      sens_ctrl_d = reg_wdata;
      write_refused_d = 1'b0;
    end else if (ctrl_wr) begin
      // A write outside level 3 leaves the field alone and is flagged.
      write_refused_d = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      sens_ctrl_q <= `SENS_CTRL_RESET;
    end else if (clk_en) begin
      sens_ctrl_q <= sens_ctrl_d;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      write_refused_q <= 1'b0;
    end else if (clk_en) begin
      write_refused_q <= write_refused_d;
    end
  end

  // ==========================================================================
  // Field extraction
  // ==========================================================================

  // Codes: 00 falling edge and low level, 01 rising, 10 falling, 11 both edges.
  // With inversion the edges and the level swap polarity on the masked pins.
  wire [1:0] group_c_sense_select = sens_ctrl_q[`GRP_C_SENSE_HI:`GRP_C_SENSE_LO];
  wire group_c_polarity_invert = sens_ctrl_q[`GRP_C_INV_BIT];
  wire [1:0] group_b_sense_select = sens_ctrl_q[`GRP_B_SENSE_HI:`GRP_B_SENSE_LO];
  wire [1:0] group_a_sense_select = sens_ctrl_q[`GRP_A_SENSE_HI:`GRP_A_SENSE_LO];
  wire group_a_polarity_invert = sens_ctrl_q[`GRP_A_INV_BIT];

  // ==========================================================================
  // Pin group detectors
  // ==========================================================================

  // Each group has its own synchronisers and detector, so activity on one
  // port never delays the edges of another.
  wire [2:0] grp_edge;
  wire [2:0] grp_level;

  // Group A: upper pins follow the inversion bit, lower pins never do.
  ext_line_detect #(
    .PINS(GRP_A_PINS),
    .INV_MASK(GRP_A_INV_MASK)
  ) u_detect_a (
    .clk(clk),
    .srst(srst),
    .clk_en(clk_en),
    .pins(ext_line_group_a),
    .pin_en(group_a_irq_en),
    .sense(group_a_sense_select),
    .invert(group_a_polarity_invert),
    .edge_any(grp_edge[0]),
    .level_any(grp_level[0])
  );

  // Group B has no inversion option.
  ext_line_detect #(
    .PINS(GRP_B_PINS),
    .INV_MASK({GRP_B_PINS{1'b0}})
  ) u_detect_b (
    .clk(clk),
    .srst(srst),
    .clk_en(clk_en),
    .pins(ext_line_group_b),
    .pin_en(group_b_irq_en),
    .sense(group_b_sense_select),
    .invert(1'b0),
    .edge_any(grp_edge[1]),
    .level_any(grp_level[1])
  );

  // Group C: upper pins follow the inversion bit, lower pins never do.
  ext_line_detect #(
    .PINS(GRP_C_PINS),
    .INV_MASK(GRP_C_INV_MASK)
  ) u_detect_c (
    .clk(clk),
    .srst(srst),
    .clk_en(clk_en),
    .pins(ext_line_group_c),
    .pin_en(group_c_irq_en),
    .sense(group_c_sense_select),
    .invert(group_c_polarity_invert),
    .edge_any(grp_edge[2]),
    .level_any(grp_level[2])
  );

  // ==========================================================================
  // Group masking and pending latches
  // ==========================================================================

  // A pin that the port drives to ground would hold its group at a low level
  // forever, so such a group is masked until the pin is released.
  wire [2:0] grp_masked;
  assign grp_masked[0] = |(group_a_irq_en & group_a_drive_low);
  assign grp_masked[1] = |(group_b_irq_en & group_b_drive_low);
  assign grp_masked[2] = |(group_c_irq_en & group_c_drive_low);

  reg [2:0] ext_pend_q;
  wire [2:0] ext_pend_d;
  wire [2:0] ext_req;

  // An acknowledge clears only the group whose vector it names.
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_group
      wire [3:0] own_vec = (g == 0) ? `VEC_GRP_A : ((g == 1) ? `VEC_GRP_B : `VEC_GRP_C);
      wire served = irq_ack & (irq_ack_vector == own_vec);
      wire clr = served | cfg_change;
      // A fresh edge in the clearing cycle survives.
      assign ext_pend_d[g] = grp_edge[g] | (ext_pend_q[g] & ~clr);
      assign ext_req[g] = (ext_pend_q[g] | grp_level[g]) & ~grp_masked[g];
    end
  endgenerate

  // Pending edges freeze with the rest of the state while clk_en is low.
  always @(posedge clk) begin
    if (srst) begin
      ext_pend_q <= 3'h0;
    end else if (clk_en) begin
      ext_pend_q <= ext_pend_d;
    end
  end

  // ==========================================================================
  // Vector map
  // ==========================================================================

  // Index 0 is the highest hardware priority and index 13 the lowest.
  // Sources that share a vector are ORed onto it.
  wire [13:0] vec_req;
  assign vec_req[0] = motor_emergency_stop;
  assign vec_req[1] = clock_timebase_unit_irq |
    safe_oscillator_switch_irq;
  assign vec_req[2] = ext_req[0];
  assign vec_req[3] = ext_req[1];
  assign vec_req[4] = ext_req[2];
  assign vec_req[5] = motor_controller_u_irq |
    motor_controller_loop_irq |
    motor_controller_sample_irq;
  assign vec_req[6] = motor_controller_r_irq |
    motor_controller_z_irq;
  assign vec_req[7] = motor_controller_c_irq |
    motor_controller_d_irq;
  assign vec_req[8] = spi_irq;
  assign vec_req[9] = timer_a_irq;
  assign vec_req[10] = timer_b_irq;
  assign vec_req[11] = async_serial_irq;
  assign vec_req[12] = aux_voltage_detector_irq |
    adc_eoc_irq;
  assign vec_req[13] = auto_reload_pwm_timer_irq;

  wire enc_any;
  wire [3:0] enc_index;
  wire [15:0] enc_addr;
  wire enc_wake;

  // While halted, the encoder only offers a source that may end the halt.
  vector_priority_encoder u_encoder (
    .req(vec_req),
    .halt_mode(halt_mode),
    .active_halt_mode(active_halt_mode),
    .any(enc_any),
    .index(enc_index),
    .addr(enc_addr),
    .wake(enc_wake)
  );

  // ==========================================================================
  // Registered request outputs
  // ==========================================================================

  // Every request output comes from a flop, one cycle after its sources.
  always @(posedge clk) begin
    if (srst) begin
      irq_valid_q <= 1'b0;
      irq_vector_q <= 4'h0;
      irq_vector_addr_q <= `VEC_ADDR_TOP;
      halt_wake_q <= 1'b0;
    end else if (clk_en) begin
      irq_valid_q <= enc_any;
      irq_vector_q <= enc_index;
      irq_vector_addr_q <= enc_addr;
      halt_wake_q <= enc_wake;
    end
  end

  // Group requests are exported on their own, so a masked or cleared group
  // can be seen without decoding the vector.
  always @(posedge clk) begin
    if (srst) begin
      ext_request_q <= 3'h0;
    end else if (clk_en) begin
      ext_request_q <= ext_req;
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================

  // Read data stand for the one cycle after the read strobe and are zero
  // otherwise, so a stale value never looks like a fresh answer.
  reg [7:0] rdata_d;

  always @* begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `SENS_CTRL_OFS: begin
          rdata_d = sens_ctrl_q;
        end
        `EXT_PEND_OFS: begin
          rdata_d = {1'b0, grp_masked, write_refused_q, ext_pend_q};
        end
        `VEC_STAT_OFS: begin
          rdata_d = {enc_any, enc_wake, 2'h0, enc_index};
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      reg_rdata_q <= 8'h00;
    end else if (clk_en) begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule // ext_interrupt_sense_and_vector_map

// File: pkg/irq_map_regs.vh
// Register offsets, field layout, reset values and vector constants of the interrupt sense block.
//
// Overview of operation
// - Emergency stop alone: vector 0.
// - Time base or safe oscillator share vector 1.
// - Groups A, B, C take vectors 2-4, wake.
// - Motor vector 5: U, loop, sampling; no wake.
// - Serial peripheral 8 wakes; timers, async serial don't.
// - Voltage detector or converter share vector 12, wake.
// - Auto-reload timer overflow is vector 13, lowest.
// - Halt wake per source; vector 1 active-halt only.
// - Changing sense or polarity clears pending external requests.
// - Group masked while an interrupt pin is grounded.
// - Four sensitivities: fall, rise, both, fall+low.
// - Rise plus high only for groups A and C.
// - Sense writes accepted only at CPU level 3.
// - Bits 7:6 select group C sensitivity codes.
// - Bit 5 inverts group C upper pins only.
// - Bits 4:3 select group B, no inversion.
// - Bits 2:1 select group A, lower pins uninverted.
// - Bit 0 inverts group A upper pins.
// - Sensitivity control resets to all zeros.
// - Edge requests latch, clear on service entry.
// - Pins of one group are ORed together.
`ifndef IRQ_MAP_REGS_VH
`define IRQ_MAP_REGS_VH

`define SENS_CTRL_OFS 4'h0
`define EXT_PEND_OFS 4'h1
`define VEC_STAT_OFS 4'h2
`define SENS_CTRL_RESET 8'h00
`define GRP_C_SENSE_HI 7
`define GRP_C_SENSE_LO 6
`define GRP_C_INV_BIT 5
`define GRP_B_SENSE_HI 4
`define GRP_B_SENSE_LO 3
`define GRP_A_SENSE_HI 2
`define GRP_A_SENSE_LO 1
`define GRP_A_INV_BIT 0
`define SENSE_FALL_LOW 2'h0
`define SENSE_RISE 2'h1
`define SENSE_FALL 2'h2
`define SENSE_BOTH 2'h3
`define PRIO_LEVEL3 2'h3
`define VEC_COUNT 14
`define VEC_ADDR_TOP 16'hFFFA
`define VEC_GRP_A 4'h2
`define VEC_GRP_B 4'h3
`define VEC_GRP_C 4'h4
`define WAKE_HALT_MASK 14'h111C
`define WAKE_ACTIVE_HALT_MASK 14'h111E

`endif

// File: src/ext_line_detect.v
// Edge and level detector for one external interrupt pin group.
`timescale 1ns/1ps
`include "irq_map_regs.vh"
module ext_line_detect #(
  parameter PINS = 4,
  parameter [PINS-1:0] INV_MASK = {PINS{1'b0}}
) (
  // Clock and reset.
  input wire clk,
  input wire srst,
  input wire clk_en,
  // Pins and configuration.
  input wire [PINS-1:0] pins,
  input wire [PINS-1:0] pin_en,
  input wire [1:0] sense,
  input wire invert,
  // Detected events.
  output wire edge_any,
  output wire level_any
);
  wire [PINS-1:0] hit;
  wire [PINS-1:0] lvl;
  genvar i;
  generate
    for (i = 0; i < PINS; i = i + 1) begin : g_pin
      reg meta_q;
      reg sync_q;
      reg prev_q;
      wire inv = invert & INV_MASK[i];
      wire cur_n = sync_q ^ inv;
      wire prev_n = prev_q ^ inv;
      wire fall = prev_n & ~cur_n;
      wire rise = ~prev_n & cur_n;
      always @(posedge clk) begin
        if (srst) begin
          meta_q <= 1'b1;
          sync_q <= 1'b1;
          prev_q <= 1'b1;
        end else if (clk_en) begin
          meta_q <= pins[i];
          sync_q <= meta_q;
          prev_q <= sync_q;
        end
      end
      // Normalised polarity keeps a change of inversion from faking an edge.
      assign hit[i] = pin_en[i] & ((sense == `SENSE_FALL_LOW) ? fall :
                                   (sense == `SENSE_RISE) ? rise :
                                   (sense == `SENSE_FALL) ? fall : (fall | rise));
      assign lvl[i] = pin_en[i] & (sense == `SENSE_FALL_LOW) & ~cur_n;
    end
  endgenerate
  assign edge_any = |hit;
  assign level_any = |lvl;
endmodule // ext_line_detect

// File: src/vector_priority_encoder.v
// Fixed hardware priority encoder with vector address and halt wake decode.
`timescale 1ns/1ps
`include "irq_map_regs.vh"
module vector_priority_encoder (
  // Requests by vector index.
  input wire [13:0] req,
  // Low-power state.
  input wire halt_mode,
  input wire active_halt_mode,
  // Selection.
  output reg any,
  output reg [3:0] index,
  output reg [15:0] addr,
  output reg wake
);
  reg [13:0] wake_mask;
  reg [13:0] cand;
  integer i;
  always @* begin
    wake_mask = 14'h0000;
    if (active_halt_mode) begin
      wake_mask = `WAKE_ACTIVE_HALT_MASK;
    end else if (halt_mode) begin
      wake_mask = `WAKE_HALT_MASK;
    end
    // While halted only a wake-capable source may be served first.
    cand = (halt_mode | active_halt_mode) ? (req & wake_mask) : req;
    wake = |(req & wake_mask);
    any = |cand;
    index = 4'h0;
    for (i = `VEC_COUNT - 1; i >= 0; i = i - 1) begin
      if (cand[i]) begin
        index = i[3:0];
      end
    end
    addr = `VEC_ADDR_TOP - {11'h000, index, 1'b0};
  end
endmodule // vector_priority_encoder

// File: dv/irq_sense_monitor.sv
// Port assertions of the interrupt sense and vector map block.
`timescale 1ns/1ps
module irq_sense_monitor #(
  parameter ADDR_W = 4
) (
  // Clock and reset.
  input wire clk,
  input wire srst,
  // Register port and CPU level.
  input wire [ADDR_W-1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata_q,
  input wire cpu_priority_high_bit,
  input wire cpu_priority_low_bit,
  // Sources, state and requests.
  input wire motor_emergency_stop,
  input wire halt_mode,
  input wire active_halt_mode,
  input wire irq_valid_q,
  input wire [3:0] irq_vector_q,
  input wire [15:0] irq_vector_addr_q,
  input wire halt_wake_q,
  input wire [2:0] ext_request_q,
  input wire [7:0] sens_ctrl_q
);
  wire ctl_wr = reg_wr && reg_addr == '0;
  wire lvl3 = cpu_priority_high_bit && cpu_priority_low_bit;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_sens_accept: assert property (ctl_wr && lvl3 |=> sens_ctrl_q == $past(reg_wdata))
    else $error("control write at level 3 not taken");
  a_sens_refuse: assert property (!(ctl_wr && lvl3) |=> $stable(sens_ctrl_q))
    else $error("control changed without an accepted write");
  a_sens_readback: assert property (reg_rd && reg_addr == '0 |=> reg_rdata_q == $past(sens_ctrl_q))
    else $error("control read back wrong");
  a_vector_addr: assert property (irq_valid_q |-> irq_vector_addr_q == 16'hFFFA - {11'h000, irq_vector_q, 1'b0})
    else $error("vector address does not match index");
  a_emergency_top: assert property (motor_emergency_stop && !halt_mode && !active_halt_mode
    |=> irq_valid_q && irq_vector_q == 4'h0)
    else $error("emergency stop not top vector");
  a_halt_nowake: assert property (irq_valid_q && $past(halt_mode) && !$past(active_halt_mode)
    |-> irq_vector_q inside {4'h2, 4'h3, 4'h4, 4'h8, 4'hC})
    else $error("vector without halt wake chosen in halt");
  a_ahalt_wake: assert property (irq_valid_q && $past(active_halt_mode)
    |-> irq_vector_q inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h8, 4'hC})
    else $error("vector without wake chosen in active halt");
  a_wake_flag: assert property ($past(halt_mode || active_halt_mode) |-> halt_wake_q == irq_valid_q)
    else $error("wake flag differs from request in halt");
  a_ext_vector: assert property (irq_valid_q && irq_vector_q inside {4'h2, 4'h3, 4'h4}
    |-> ext_request_q[irq_vector_q - 4'h2])
    else $error("external vector without its group request");
  a_ext_first: assert property (ext_request_q[0] && !$past(halt_mode) && !$past(active_halt_mode)
    |-> irq_valid_q && irq_vector_q <= 4'h2)
    else $error("group a request outranked by lower vector");
endmodule // irq_sense_monitor

bind ext_interrupt_sense_and_vector_map irq_sense_monitor #(.ADDR_W(ADDR_W)) i_mon (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .cpu_priority_high_bit(cpu_priority_high_bit),
  .cpu_priority_low_bit(cpu_priority_low_bit), .motor_emergency_stop(motor_emergency_stop),
  .halt_mode(halt_mode), .active_halt_mode(active_halt_mode), .irq_valid_q(irq_valid_q),
  .irq_vector_q(irq_vector_q), .irq_vector_addr_q(irq_vector_addr_q), .halt_wake_q(halt_wake_q),
  .ext_request_q(ext_request_q), .sens_ctrl_q(sens_ctrl_q));

// File: dv/irq_sequencer_model.sv
// Interrupt sequencer model that enters service of the requested vector.
`timescale 1ns/1ps
module irq_sequencer_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Bench control.
  input wire logic ack_en,
  input wire logic slow,
  // Request and service entry.
  input wire logic irq_valid_q,
  input wire logic [3:0] irq_vector_q,
  output logic irq_ack,
  output logic [3:0] irq_ack_vector
);
  logic [2:0] wait_q;
  always @(posedge clk) begin
    if (srst) begin
      irq_ack <= 1'b0;
      wait_q <= 3'h0;
      irq_ack_vector <= 4'hF;
    end else if (irq_ack) begin
      // The vector lines do not keep their last value once the pulse ends.
      irq_ack <= 1'b0;
      wait_q <= 3'h0;
      irq_ack_vector <= ~irq_ack_vector;
    end else if (ack_en && irq_valid_q) begin
      wait_q <= wait_q + 3'h1;
      if (wait_q >= (slow ? 3'h3 : 3'h0)) begin
        irq_ack <= 1'b1;
        irq_ack_vector <= irq_vector_q;
      end
    end
  end
endmodule // irq_sequencer_model

// File: dv/ext_interrupt_sense_and_vector_map_tb_top.sv
// Self-checking testbench of the interrupt sense and vector map block.
`timescale 1ns/1ps
module ext_interrupt_sense_and_vector_map_tb_top;
  // ====================
  // Stimulus and design.
  logic clk = 1'b0, srst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic [3:0] reg_addr = 4'h0, ext_line_group_b = 4'hF, group_b_irq_en = 4'hF, group_b_drive_low = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic cpu_priority_high_bit = 1'b1, cpu_priority_low_bit = 1'b1;
  logic [5:0] ext_line_group_a = 6'h3F, ext_line_group_c = 6'h3F, group_a_irq_en = 6'h3F;
  logic [5:0] group_c_irq_en = 6'h3F, group_a_drive_low = 6'h00, group_c_drive_low = 6'h00;
  logic [16:0] src = 17'h00000;
  logic halt_mode = 1'b0, active_halt_mode = 1'b0, ack_en = 1'b0, slow = 1'b0;
  wire irq_ack, irq_valid_q, halt_wake_q;
  wire [3:0] irq_ack_vector, irq_vector_q;
  wire [15:0] irq_vector_addr_q;
  wire [2:0] ext_request_q;
  wire [7:0] reg_rdata_q, sens_ctrl_q;
  int failures = 0, samples_checked = 0;
  typedef struct {string nm; logic [7:0] v; logic [7:0] m;} note_t;
  note_t notes[$];
  note_t n;
  int idx_t[17] = '{0, 1, 1, 5, 5, 5, 6, 6, 7, 7, 8, 9, 10, 11, 12, 12, 13};
  always #2 clk = ~clk;
  ext_interrupt_sense_and_vector_map i_dut (.motor_emergency_stop(src[0]), .clock_timebase_unit_irq(src[1]),
    .safe_oscillator_switch_irq(src[2]), .motor_controller_u_irq(src[3]), .motor_controller_loop_irq(src[4]),
    .motor_controller_sample_irq(src[5]), .motor_controller_r_irq(src[6]), .motor_controller_z_irq(src[7]),
    .motor_controller_c_irq(src[8]), .motor_controller_d_irq(src[9]), .spi_irq(src[10]),
    .timer_a_irq(src[11]), .timer_b_irq(src[12]), .async_serial_irq(src[13]),
    .aux_voltage_detector_irq(src[14]), .adc_eoc_irq(src[15]), .auto_reload_pwm_timer_irq(src[16]), .*);
  irq_sequencer_model i_seq (.clk(clk), .srst(srst), .ack_en(ack_en), .slow(slow), .irq_valid_q(irq_valid_q),
    .irq_vector_q(irq_vector_q), .irq_ack(irq_ack), .irq_ack_vector(irq_ack_vector));
  function automatic logic wake_ok(input int i, input logic act);
    return i == 2 || i == 3 || i == 4 || i == 8 || i == 12 || (act && i == 1);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m, input string nm);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    notes.push_back('{nm, e & m, m});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic clr(input logic [7:0] c, input logic [7:0] alt);
    repeat (2) begin
      wr(4'h0, alt);
      wr(4'h0, c);
    end
  endtask
  task automatic pin(input int g, input int p, input logic v);
    @(posedge clk);
    case (g)
      0: ext_line_group_a[p] <= v;
      1: ext_line_group_b[p] <= v;
      default: ext_line_group_c[p] <= v;
    endcase
    repeat (6) @(posedge clk);
  endtask
  task automatic final_report();
    $display("Checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ====================
  // Result monitor.
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d && notes.size() > 0) begin
      n = notes.pop_front();
      samples_checked++;
      if ((reg_rdata_q & n.m) !== n.v) begin
        failures++;
        $display("MISMATCH %s expected %h seen %h", n.nm, n.v, reg_rdata_q & n.m);
      end
    end
  end
  initial begin
    #100000;
    failures++;
    final_report();
  end
  // ====================
  // Test sequence.
  initial begin
    int g, code, inv, pp, p, k, j, hm, best;
    logic f, r, ei;
    logic [7:0] cfg, alt;
    logic [16:0] s;
    void'($urandom(32'hA91EA0FB));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(4'h0, 8'h00, 8'hFF, "control reset");
    rd(4'hF, 8'h00, 8'hFF, "unmapped read");
    for (k = 0; k < 4; k++) begin
      @(posedge clk);
      {cpu_priority_high_bit, cpu_priority_low_bit} <= k == 3 ? 2'b11 : (k == 0 ? 2'b10 : (k == 1 ? 2'b01 : 2'b00));
      wr(4'h0, 8'hA5);
      rd(4'h0, k == 3 ? 8'hA5 : 8'h00, 8'hFF, "level gated write");
      rd(4'h1, k == 3 ? 8'h00 : 8'h08, 8'h08, "refused flag");
    end
    for (g = 0; g < 3; g++)
      for (code = 0; code < 4; code++)
        for (inv = 0; inv < 2; inv++)
          for (pp = 0; pp < 2; pp++) begin
            p = pp ? (g == 1 ? 3 : 5) : 0;
            ei = inv && g != 1 && pp;
            f = ei ? code[0] : code != 1;
            r = ei ? code != 1 : code[0];
            cfg = g == 0 ? {5'h00, code[1:0], inv[0]} : (g == 1 ? {3'h0, code[1:0], 3'h0} : {code[1:0], inv[0], 5'h00});
            alt = cfg ^ (g == 1 ? 8'h01 : 8'h18);
            clr(cfg, alt);
            pin(g, p, 1'b0);
            rd(4'h1, 8'(f) << g, 8'h01 << g, "falling edge pending");
            clr(cfg, alt);
            pin(g, p, 1'b1);
            rd(4'h1, 8'(r) << g, 8'h01 << g, "rising edge pending");
          end
    clr(8'h80, 8'h98);
    pin(2, 0, 1'b0);
    wr(4'h0, 8'h80);
    rd(4'h1, 8'h04, 8'h04, "same value keeps pending");
    wr(4'h0, 8'hC0);
    rd(4'h1, 8'h00, 8'h04, "new value clears pending");
    pin(2, 0, 1'b1);
    clr(8'h00, 8'h18);
    pin(1, 1, 1'b0);
    @(posedge clk);
    group_b_irq_en[3] <= 1'b0;
    group_b_drive_low[3] <= 1'b1;
    rd(4'h2, 8'h83, 8'hBF, "unmasked group request");
    group_b_irq_en[3] <= 1'b1;
    repeat (3) @(posedge clk);
    rd(4'h1, 8'h20, 8'h20, "group mask flag");
    rd(4'h2, 8'h00, 8'hBF, "masked group request");
    group_b_drive_low[3] <= 1'b0;
    ack_en <= 1'b1;
    slow <= 1'($urandom);
    repeat (20) @(posedge clk);
    rd(4'h2, 8'h83, 8'hBF, "level request held");
    pin(1, 1, 1'b1);
    repeat (10) @(posedge clk);
    rd(4'h2, 8'h00, 8'hBF, "level request released");
    clr(8'h80, 8'h98);
    pin(2, 0, 1'b0);
    repeat (10) @(posedge clk);
    rd(4'h1, 8'h00, 8'h04, "edge cleared on service");
    pin(2, 0, 1'b1);
    ack_en <= 1'b0;
    clr(8'h00, 8'h18);
    for (k = 0; k < 81; k++) begin
      s = k < 51 ? 17'h00001 << (k / 3) : 17'($urandom);
      hm = k % 3;
      @(posedge clk);
      src <= s;
      halt_mode <= hm == 1;
      active_halt_mode <= hm == 2;
      best = 14;
      for (j = 0; j < 17; j++)
        if (s[j] && (hm == 0 || wake_ok(idx_t[j], hm == 2)) && idx_t[j] < best) best = idx_t[j];
      repeat (2) @(posedge clk);
      rd(4'h2, best == 14 ? 8'h00 : (8'h80 | (hm != 0 ? 8'h40 : 8'h00) | 8'(best)),
        hm != 0 ? 8'hFF : 8'hBF, "vector status");
    end
    src <= 17'h00000;
    halt_mode <= 1'b0;
    active_halt_mode <= 1'b0;
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule // ext_interrupt_sense_and_vector_map_tb_top
